// [rtl/ccs_map.svh]
/*
 * Register indices, field positions, reset values and timing counts of the
 * clock-control settings block.
 * Assumes an APB master with 32-bit data; byte address is four times an index.
 */
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// What this block does
// - The watchdog interrupt time-out is 2^17, 2^20, 2^23 or 2^26 clocks for period codes 00 to 11.
// - The watchdog reset follows exactly 512 clocks after the interrupt time-out unless cleared.
// - An external data move with stretch value N lasts N plus 2 machine cycles.
// - After reset the stretch field holds 1, giving 3-machine-cycle moves.

// ****************************************************************
// Register indices
// ****************************************************************
`define CCS_IDX_WD_CTL 8'h80
`define CCS_IDX_CLK_CTL 8'h8e
`define CCS_IDX_T3_SEL 8'h8f

// ****************************************************************
// Field positions
// ****************************************************************
`define CCS_WDP_HI 7
`define CCS_WDP_LO 6
`define CCS_STR_HI 2
`define CCS_STR_LO 0
`define CCS_T3_HI 1
`define CCS_T3_LO 0
`define CCS_WD_EN 0
`define CCS_WD_CLR 1
`define CCS_WD_IFLG 2
`define CCS_WD_RFLG 3

// ****************************************************************
// Reset values
// ****************************************************************
`define CCS_WDP_RESET 2'h0
`define CCS_STR_RESET 3'h1
`define CCS_T3_RESET 2'h0

// ****************************************************************
// Timing counts
// ****************************************************************
`define CCS_RST_GAP 27'h200
`define CCS_MC_CLKS 6'h4
`define CCS_STR_MIN 6'h2
`define CCS_DIV_1 6'h01
`define CCS_DIV_4 6'h04
`define CCS_DIV_16 6'h10
`define CCS_DIV_32 6'h20

`endif

// [rtl/ccs_pkg.sv]
/*
 * Types and shared decode functions of the clock-control settings block.
 * Assumes the constants header is on the include path.
 */
`include "ccs_map.svh"

package ccs_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        CCS_MV_IDLE = 2'b01,
        CCS_MV_BUSY = 2'b10
    } ccs_move_state_t;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Clocks in one whole external move for a stretch value.
    function automatic logic [5:0] ccs_move_clocks(input logic [2:0] stretch);
        ccs_move_clocks = 6'(({3'h0, stretch} + `CCS_STR_MIN) * `CCS_MC_CLKS);
    endfunction

    // Oscillator clocks between two timer 3 ticks.
    function automatic logic [5:0] ccs_t3_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: ccs_t3_div = `CCS_DIV_1;
            2'h1: ccs_t3_div = `CCS_DIV_4;
            2'h2: ccs_t3_div = `CCS_DIV_16;
            2'h3: ccs_t3_div = `CCS_DIV_32;
        endcase
    endfunction

endpackage

// [rtl/ccs_t3_prescaler.sv]
/*
 * Timer 3 clock prescaler: a one-cycle tick every 1, 4, 16 or 32 clocks.
 * Assumes the select comes from a register on the same clock.
 */
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_t3_prescaler
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic [1:0] sel,
    // Tick
    output logic tick
);

    logic [5:0] cnt_reg;
    logic [5:0] lastCount;
    logic tick_reg;

    assign lastCount = ccs_pkg::ccs_t3_div(sel) - 6'h1;

    // A select change may leave the count above the new limit, so wrap on >=.
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_reg <= 6'h0;
        else if (ce)
        begin
            if (cnt_reg >= lastCount)
                cnt_reg <= 6'h0;
            else
                cnt_reg <= cnt_reg + 6'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            tick_reg <= 1'b0;
        else if (ce)
            tick_reg <= cnt_reg >= lastCount;
    end

    assign tick = tick_reg;

endmodule // ccs_t3_prescaler

// [rtl/ccs_top.sv]
/*
 * Clock-control settings: APB register file, external move stretch timer,
 * watchdog time-out and timer 3 prescaler.
 * Assumes an APB master on clk; moveStart comes from core logic on clk.
 */
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_top
#(
    parameter int unsigned WDT_INT_CLKS0 = 32'h0002_0000,
    parameter int unsigned WDT_INT_CLKS1 = 32'h0010_0000,
    parameter int unsigned WDT_INT_CLKS2 = 32'h0080_0000,
    parameter int unsigned WDT_INT_CLKS3 = 32'h0400_0000
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External data move
    input wire logic moveStart,
    output logic moveBusy,
    // Timer 3 clock enable
    output logic timer3Tick,
    // Watchdog events
    output logic wdtIntPulse,
    output logic wdtResetPulse
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0] wdPeriod_reg;
    logic [2:0] stretch_reg;
    logic [1:0] t3Sel_reg;
    logic wdEnable_reg;
    logic wdClear_reg;
    logic wdIntFlag_reg;
    logic wdRstFlag_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] readValue;
    logic mapped;
    logic setupPhase;
    logic wrDone;
    logic [7:0] regIdx;
    logic hitWd;
    logic hitClk;
    logic hitT3;
    ccs_pkg::ccs_move_state_t moveState_reg;
    logic [5:0] moveCnt_reg;
    logic moveBusy_reg;
    logic wdInt;
    logic wdRst;

    // Interrupt limit for a period code.
    function automatic logic [26:0] wdLimit(input logic [1:0] period);
        unique case (period)
            2'h0: wdLimit = WDT_INT_CLKS0[26:0];
            2'h1: wdLimit = WDT_INT_CLKS1[26:0];
            2'h2: wdLimit = WDT_INT_CLKS2[26:0];
            2'h3: wdLimit = WDT_INT_CLKS3[26:0];
        endcase
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign regIdx = paddr[9:2];
    assign hitWd = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && regIdx == `CCS_IDX_WD_CTL;
    assign hitClk = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && regIdx == `CCS_IDX_CLK_CTL;
    assign hitT3 = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && regIdx == `CCS_IDX_T3_SEL;
    assign mapped = hitWd || hitClk || hitT3;
    assign setupPhase = psel && !penable;
    assign wrDone = psel && penable && pready_reg && pwrite;

    always_comb
    begin
        readValue = 32'h0;
        if (hitWd)
        begin
            readValue[`CCS_WD_EN] = wdEnable_reg;
            readValue[`CCS_WD_IFLG] = wdIntFlag_reg;
            readValue[`CCS_WD_RFLG] = wdRstFlag_reg;
        end
        else if (hitClk)
        begin
            readValue[`CCS_WDP_HI:`CCS_WDP_LO] = wdPeriod_reg;
            readValue[`CCS_STR_HI:`CCS_STR_LO] = stretch_reg;
        end
        else if (hitT3)
            readValue[`CCS_T3_HI:`CCS_T3_LO] = t3Sel_reg;
    end

    // Zero-wait answer: the access phase always completes at its first edge.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end
        else if (ce)
        begin
            pready_reg <= setupPhase;
            pslverr_reg <= setupPhase && !mapped;
            if (setupPhase)
                prdata_reg <= pwrite ? 32'h0 : readValue;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wdPeriod_reg <= `CCS_WDP_RESET;
            stretch_reg <= `CCS_STR_RESET;
        end
        else if (ce && wrDone && hitClk)
        begin
            wdPeriod_reg <= pwdata[`CCS_WDP_HI:`CCS_WDP_LO];
            stretch_reg <= pwdata[`CCS_STR_HI:`CCS_STR_LO];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            t3Sel_reg <= `CCS_T3_RESET;
        else if (ce && wrDone && hitT3)
            t3Sel_reg <= pwdata[`CCS_T3_HI:`CCS_T3_LO];
    end

    // A period change restarts the count so no stale limit is ever compared.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wdEnable_reg <= 1'b0;
            wdClear_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (wrDone && hitWd)
                wdEnable_reg <= pwdata[`CCS_WD_EN];
            wdClear_reg <= wrDone && ((hitWd && pwdata[`CCS_WD_CLR]) || hitClk);
        end
    end

    // Sticky event flags, write one to clear; a new event wins over the clear.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wdIntFlag_reg <= 1'b0;
            wdRstFlag_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (wdInt)
                wdIntFlag_reg <= 1'b1;
            else if (wrDone && hitWd && pwdata[`CCS_WD_IFLG])
                wdIntFlag_reg <= 1'b0;
            if (wdRst)
                wdRstFlag_reg <= 1'b1;
            else if (wrDone && hitWd && pwdata[`CCS_WD_RFLG])
                wdRstFlag_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // External move stretch
    // ****************************************************************
    // The stretch is latched at the start, so a mid-move write has no effect.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            moveState_reg <= ccs_pkg::CCS_MV_IDLE;
            moveCnt_reg <= 6'h0;
            moveBusy_reg <= 1'b0;
        end
        else if (ce)
        begin
            unique case (moveState_reg)
                ccs_pkg::CCS_MV_IDLE:
                begin
                    if (moveStart)
                    begin
                        moveCnt_reg <= ccs_pkg::ccs_move_clocks(stretch_reg) - 6'h1;
                        moveBusy_reg <= 1'b1;
                        moveState_reg <= ccs_pkg::CCS_MV_BUSY;
                    end
                end
                ccs_pkg::CCS_MV_BUSY:
                begin
                    if (moveCnt_reg == 6'h0)
                    begin
                        moveBusy_reg <= 1'b0;
                        moveState_reg <= ccs_pkg::CCS_MV_IDLE;
                    end
                    else
                        moveCnt_reg <= moveCnt_reg - 6'h1;
                end
                default:
                begin
                    moveBusy_reg <= 1'b0;
                    moveState_reg <= ccs_pkg::CCS_MV_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Watchdog and timer 3 prescaler
    // ****************************************************************
    ccs_watchdog u_watchdog
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .enable(wdEnable_reg),
        .clear(wdClear_reg),
        .intLimit(wdLimit(wdPeriod_reg)),
        .intPulse(wdInt),
        .rstPulse(wdRst)
    );

    ccs_t3_prescaler u_t3_prescaler
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sel(t3Sel_reg),
        .tick(timer3Tick)
    );

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign moveBusy = moveBusy_reg;
    assign wdtIntPulse = wdInt;
    assign wdtResetPulse = wdRst;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [27:0] chkElapsed;
    logic [9:0] chkSinceInt;
    logic [5:0] chkBusyLen;
    logic [5:0] chkMoveExp;
    logic [5:0] chkGap;
    logic chkGapValid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chkElapsed <= 28'h0;
            chkSinceInt <= 10'h0;
            chkBusyLen <= 6'h0;
            chkMoveExp <= 6'h0;
            chkGap <= 6'h0;
            chkGapValid <= 1'b0;
        end
        else if (ce)
        begin
            chkElapsed <= (!wdEnable_reg || wdClear_reg || wdRst) ? 28'h0 : chkElapsed + 28'h1;
            chkSinceInt <= wdInt ? 10'h1 : chkSinceInt + 10'h1;
            chkBusyLen <= moveBusy_reg ? chkBusyLen + 6'h1 : 6'h0;
            if (moveState_reg == ccs_pkg::CCS_MV_IDLE && moveStart)
                chkMoveExp <= ccs_pkg::ccs_move_clocks(stretch_reg);
            chkGap <= timer3Tick ? 6'h1 : chkGap + 6'h1;
            if (wrDone && hitT3)
                chkGapValid <= 1'b0;
            else if (timer3Tick)
                chkGapValid <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_wdt_int_limit: assert property (wdInt |-> chkElapsed == 28'(wdLimit(wdPeriod_reg)))
        else $error("watchdog interrupt not at the selected limit");
    a_wdt_rst_gap: assert property (wdRst |-> chkSinceInt == 10'h200)
        else $error("watchdog reset not 512 clocks after interrupt");
    a_move_length: assert property (
        $fell(moveBusy_reg) && $past(ce) |-> chkBusyLen == chkMoveExp)
        else $error("external move length wrong");
    a_stretch_write: assert property (
        ce && wrDone && hitClk |=> stretch_reg == $past(pwdata[`CCS_STR_HI:`CCS_STR_LO]))
        else $error("stretch field write lost");
    a_stretch_reset: assert property (
        $past(rst) |-> stretch_reg == `CCS_STR_RESET && !moveBusy_reg)
        else $error("stretch reset value wrong");
    a_t3_tick_gap: assert property (
        timer3Tick && ce && chkGapValid |-> chkGap == ccs_pkg::ccs_t3_div(t3Sel_reg))
        else $error("timer 3 tick spacing wrong");
    a_t3_reserved_bits: assert property (
        psel && penable && pready_reg && !pwrite && hitT3 |-> prdata_reg[31:2] == 30'h0)
        else $error("timer 3 select reserved bits not zero");
    a_apb_unmapped: assert property (ce && setupPhase && !mapped |=> pready_reg && pslverr_reg)
        else $error("unmapped access not refused");

    c_wdt_reset: cover property (wdRst);
    c_long_move: cover property ($rose(moveBusy_reg) && stretch_reg == 3'h7);
    c_t3_div32: cover property (timer3Tick && t3Sel_reg == 2'h3 && chkGapValid);

endmodule // ccs_top

// [rtl/ccs_watchdog.sv]
/*
 * Watchdog time-out counter: interrupt pulse at the chosen limit, reset
 * pulse a fixed gap later.
 * Assumes enable, clear and limit come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_watchdog
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic enable,
    input wire logic clear,
    input wire logic [26:0] intLimit,
    // Events
    output logic intPulse,
    output logic rstPulse
);

    logic [26:0] cnt_reg;
    logic [26:0] cnt_next;
    logic [26:0] rstLimit;
    logic intPulse_reg;
    logic rstPulse_reg;

    assign rstLimit = intLimit + `CCS_RST_GAP;
    assign cnt_next = cnt_reg + 27'h1;

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_reg <= 27'h0;
        else if (ce)
        begin
            if (!enable || clear || cnt_reg == rstLimit)
                cnt_reg <= 27'h0;
            else
                cnt_reg <= cnt_next;
        end
    end

    // ****************************************************************
    // Time-out events
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            intPulse_reg <= 1'b0;
            rstPulse_reg <= 1'b0;
        end
        else if (ce)
        begin
            intPulse_reg <= enable && !clear && cnt_next == intLimit;
            rstPulse_reg <= enable && !clear && cnt_next == rstLimit;
        end
    end

    assign intPulse = intPulse_reg;
    assign rstPulse = rstPulse_reg;

endmodule // ccs_watchdog

// [verification/ccs_testbench.sv]
/*
 * Self-checking testbench of the clock-control settings block.
 * Assumes ccs_top with an APB slave answering within a few cycles and
 * watchdog limits shortened through its parameters.
 */
`timescale 1ns/1ps
`include "ccs_map.svh"

module testbench;

    // ****************************************************************
    // Signals and instance
    // ****************************************************************
    localparam logic [11:0] ADDR_WD = 12'({`CCS_IDX_WD_CTL, 2'b00});
    localparam logic [11:0] ADDR_CLK = 12'({`CCS_IDX_CLK_CTL, 2'b00});
    localparam logic [11:0] ADDR_T3 = 12'({`CCS_IDX_T3_SEL, 2'b00});
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic moveStart = 1'b0;
    logic moveBusy;
    logic timer3Tick;
    logic wdtIntPulse;
    logic wdtResetPulse;
    int nMismatch = 0;
    int nTests = 0;

    always #2 clk = ~clk;

    // Short limits keep the run brief; expectations use the same values.
    ccs_top #(.WDT_INT_CLKS0(64), .WDT_INT_CLKS1(128), .WDT_INT_CLKS2(256),
        .WDT_INT_CLKS3(1024)) dut_u
    (
        .clk(clk), .rst(rst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .moveStart(moveStart), .moveBusy(moveBusy), .timer3Tick(timer3Tick),
        .wdtIntPulse(wdtIntPulse), .wdtResetPulse(wdtResetPulse)
    );

    // ****************************************************************
    // Common tasks
    // ****************************************************************
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        nTests++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stuck(input string what);
        nMismatch++;
        $display("[ERR] %0t wait ran out: %s", $time, what);
        close_out();
    endtask

    // Samples taken right after an edge see the values from before it.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            stuck("apb");
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: pick = wdtIntPulse;
            1: pick = wdtResetPulse;
            default: pick = timer3Tick;
        endcase
    endfunction

    task automatic count_to(input int which, input int bound, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pick(which) !== 1'b1 && n < bound);
        if (pick(which) !== 1'b1)
            stuck("event");
    endtask

    // A second start a few cycles in must be ignored.
    task automatic move_run(input int expClks);
        int n;
        int k;
        n = 0;
        @(posedge clk);
        moveStart <= 1'b1;
        @(posedge clk);
        moveStart <= 1'b0;
        for (k = 1; k < 100; k++)
        begin
            @(posedge clk);
            if (k == 3)
                moveStart <= 1'b1;
            if (k == 4)
                moveStart <= 1'b0;
            if (moveBusy === 1'b1)
                n++;
            else if (k > 1)
                break;
        end
        if (k >= 100)
            stuck("move");
        check(n, expClks, "move length");
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic scen_reset_and_moves();
        logic [31:0] rd;
        logic err;
        apb(1'b0, ADDR_WD, 32'h0, rd, err);
        check(rd, 32'h0, "watchdog control reset");
        apb(1'b0, ADDR_CLK, 32'h0, rd, err);
        check(rd, 32'h1, "clock control reset");
        apb(1'b0, ADDR_T3, 32'h0, rd, err);
        check(rd, 32'h0, "prescale reset");
        move_run(12);
        for (int s = 0; s < 8; s++)
        begin
            apb(1'b1, ADDR_CLK, 32'(s), rd, err);
            move_run((s + 2) * 4);
        end
    endtask

    task automatic scen_registers();
        logic [31:0] rd;
        logic err;
        apb(1'b1, ADDR_T3, 32'hffff_ffff, rd, err);
        apb(1'b0, ADDR_T3, 32'h0, rd, err);
        check(rd, 32'h3, "reserved bits");
        apb(1'b0, 12'h204, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'b1, 12'h234, 32'h5, rd, err);
        check(32'(err), 32'h1, "unmapped write");
        apb(1'b0, 12'h239, 32'h0, rd, err);
        check(32'(err), 32'h1, "misaligned read");
    endtask

    task automatic scen_prescaler();
        int divs[4] = '{1, 4, 16, 32};
        logic [31:0] rd;
        logic err;
        int n;
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, ADDR_T3, 32'(s), rd, err);
            count_to(2, 80, n);
            count_to(2, 80, n);
            check(32'(n), 32'(divs[s]), "tick spacing");
        end
    endtask

    // Enable and clear land together; the count restarts one edge later and
    // the pulse is seen one edge after it is set, hence two extra edges.
    task automatic scen_watchdog();
        int lims[4] = '{64, 128, 256, 1024};
        logic [31:0] rd;
        logic err;
        int n;
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, ADDR_CLK, 32'((p << 6) | 1), rd, err);
            apb(1'b1, ADDR_WD, 32'h3, rd, err);
            count_to(0, 1200, n);
            check(32'(n - 2), 32'(lims[p]), "interrupt time-out");
            count_to(1, 600, n);
            check(32'(n), 32'd512, "reset gap");
            apb(1'b0, ADDR_WD, 32'h0, rd, err);
            check(rd, 32'hd, "watchdog flags");
            apb(1'b1, ADDR_WD, 32'hc, rd, err);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        scen_reset_and_moves();
        scen_registers();
        scen_prescaler();
        scen_watchdog();
        close_out();
    end

endmodule // testbench
